// *** dfpr_regs.sv ***
// Frequency offset register bank of a digitally pulled oscillator.
// Assumes a host on dfpr_if that holds req until ack; oe_pin comes from a pin.
// What this block does
// RULE1: Offset is one 26-bit two's complement value
// RULE2: Offset resets to zero, nominal frequency
// RULE3: Low 16 bits at 0x00, upper 10 at 0x01
// RULE4: Host writes low word before high word
// RULE5: Frequency changes only after high word write
// RULE6: Low word staged, all bits applied together
// RULE7: Four-bit field at 0x02 selects pull range
// RULE8: Value 33,554,431 is positive range end
// RULE9: Shift never exceeds selected pull range limits; for one cycle after a range write applied_shift uses the old range
// RULE10: Resets to factory range, both stay writable
// RULE11: Updates take effect at most 38 kHz; only offsets are paced, range writes take effect at once
// RULE12: Host sets drive bit with high word
// RULE13: Drive bit acts only under software control
// RULE14: Drive bit resets to zero, one enables
// RULE15: Unused bits read zero, ignore writes
`default_nettype none

module dfpr_regs import dfpr_pkg::*; #(
   parameter logic [3:0] FACTORY_RANGE = 4'h9 // Range code loaded at reset
) (
   dfpr_if.dev bus,
   input wire logic sw_drive_mode,
   input wire logic oe_pin,
   output logic drive_en,
   output logic [25:0] applied_offset,
   output logic [3:0] applied_range,
   output logic signed [19:0] applied_shift,
   output logic update_strobe
);

   // Register port state
   logic [15:0] low_ff, nxt_low;         // Staged low offset word
   logic [9:0] high_ff, nxt_high;        // Last written high offset word
   logic drive_ff, nxt_drive;            // Software drive enable
   logic [3:0] range_ff, nxt_range;      // Selected pull range
   logic ack_ff, nxt_ack;                // Answer pulse
   logic [15:0] rdata_ff, nxt_rdata;     // Read data

   // Apply path state
   logic [25:0] pend_ff, nxt_pend;       // Full offset awaiting its slot
   logic pend_vld_ff, nxt_pend_vld;      // A complete offset is waiting
   logic [25:0] offset_ff, nxt_offset;   // Offset in use
   logic [10:0] gap_ff, nxt_gap;         // Cycles left before next apply
   logic upd_ff, nxt_upd;                // Apply pulse
   logic signed [19:0] shift_ff, nxt_shift; // Scaled shift in use

   // Pin synchroniser for the hardware drive enable
   logic oe_meta_ff, oe_sync_ff;

   // Combinational helpers of the port and of the shift
   logic take;                           // Request accepted this cycle
   logic apply;                          // Pending offset goes live
   logic signed [25:0] lim;              // Offset limited to the range
   logic signed [45:0] prod;             // Offset times span

   // Each request is taken once; the ack cycle blocks a second take of the
   // same held request
   // A host that keeps req high past its ack gets a second access two edges
   // after the first, so the host must drop or change req on seeing ack
   assign take = bus.req && !ack_ff;
   // A waiting offset goes live only once the pacing gap has run out, which
   // keeps applied updates under the update rate whatever the bus speed
   assign apply = pend_vld_ff && (gap_ff == 11'd0); // RULE11

   // Register writes and reads
   // Unused bits never reach a flop, so they read back as zeros
   always_comb begin
      nxt_low = low_ff;
      nxt_high = high_ff;
      nxt_drive = drive_ff;
      nxt_range = range_ff;
      nxt_ack = take;
      nxt_rdata = rdata_ff;
      if (take && bus.we) begin
         case (bus.addr)
            DFPR_ADDR_LOW: begin
               // Staged only; the offset in use is untouched
               nxt_low = bus.wdata; // RULE3 RULE6
            end
            DFPR_ADDR_HIGH: begin
               // Bits 15:11 are dropped here and read back as zeros
               nxt_high = bus.wdata[DFPR_HIGH_W-1:0]; // RULE3
               // Pin control leaves the bit as it was
               if (sw_drive_mode) begin
                  nxt_drive = bus.wdata[DFPR_DRIVE_BIT]; // RULE13
               end
            end
            DFPR_ADDR_RANGE: begin
               // Span changes at once; range writes are not paced
               nxt_range = bus.wdata[DFPR_RANGE_W-1:0]; // RULE7 RULE10
            end
            default: begin
               // Unmapped writes are dropped
            end
         endcase
      end else if (take) begin
         // Read data comes from a flop, so it stands steady with ack
         case (bus.addr)
            DFPR_ADDR_LOW: nxt_rdata = low_ff;
            DFPR_ADDR_HIGH: nxt_rdata = {5'h00, drive_ff, high_ff}; // RULE15
            DFPR_ADDR_RANGE: nxt_rdata = {12'h000, range_ff}; // RULE15
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   // Register port flops; reset loads the power-up register map
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         low_ff <= DFPR_LOW_RST; // RULE2
         high_ff <= DFPR_HIGH_RST; // RULE2
         drive_ff <= DFPR_DRIVE_RST; // RULE14
         range_ff <= FACTORY_RANGE; // RULE10
         ack_ff <= 1'b0;
         rdata_ff <= 16'h0000;
      end else begin
         low_ff <= nxt_low;
         high_ff <= nxt_high;
         drive_ff <= nxt_drive;
         range_ff <= nxt_range;
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   // Offset staging, pacing and scaling; a newer high-word write while one
   // is waiting replaces it, so only the latest request reaches the output
   always_comb begin
      nxt_pend = pend_ff;
      nxt_pend_vld = pend_vld_ff;
      nxt_offset = offset_ff;
      nxt_gap = gap_ff;
      nxt_upd = 1'b0;
      // Gap counts down to zero and rests there
      if (gap_ff != 11'd0) begin
         nxt_gap = gap_ff - 11'd1;
      end
      if (apply) begin
         // Reload the gap at the moment the new offset goes live
         nxt_offset = pend_ff; // RULE5
         nxt_pend_vld = 1'b0;
         nxt_upd = 1'b1;
         nxt_gap = 11'(DFPR_GAP_CYC - 1); // RULE11
      end
      // A new full word wins over the slot that empties in the same cycle
      if (take && bus.we && bus.addr == DFPR_ADDR_HIGH) begin
         nxt_pend = {bus.wdata[DFPR_HIGH_W-1:0], low_ff}; // RULE1 RULE5 RULE6
         nxt_pend_vld = 1'b1;
      end
   end

   // Limit the most negative code so both ends of the span are symmetric
   // The shift is floored, not rounded: one least step of accuracy is traded
   // for a plain arithmetic shift instead of a divider
   always_comb begin
      lim = $signed(offset_ff);
      if (lim < DFPR_NEG_FULL) begin
         lim = DFPR_NEG_FULL; // RULE9
      end
      prod = 46'(lim) * $signed({1'b0, dfpr_span(range_ff)}); // RULE8
      nxt_shift = 20'(prod >>> DFPR_FS_SHIFT); // RULE9
   end

   // Apply path flops; reset leaves the oscillator at nominal frequency
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         pend_ff <= DFPR_OFFSET_RST;
         pend_vld_ff <= 1'b0;
         offset_ff <= DFPR_OFFSET_RST; // RULE2
         gap_ff <= 11'd0;
         upd_ff <= 1'b0;
         shift_ff <= 20'sd0;
      end else begin
         pend_ff <= nxt_pend;
         pend_vld_ff <= nxt_pend_vld;
         offset_ff <= nxt_offset;
         gap_ff <= nxt_gap;
         upd_ff <= nxt_upd;
         shift_ff <= nxt_shift;
      end
   end

   // Two flops before the pin level is used
   // Only the second flop is read; the first may still be settling
   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         oe_meta_ff <= 1'b0;
         oe_sync_ff <= 1'b0;
      end else begin
         oe_meta_ff <= oe_pin;
         oe_sync_ff <= oe_meta_ff;
      end
   end

   // Outputs; the range takes effect at once, the offset through pacing
   // applied_shift lags applied_offset and the range by one cycle
   // drive_en is a mux of two flops; sw_drive_mode must share this clock
   assign drive_en = sw_drive_mode ? drive_ff : oe_sync_ff; // RULE13 RULE14
   assign applied_offset = offset_ff;
   assign applied_range = range_ff;
   assign applied_shift = shift_ff;
   assign update_strobe = upd_ff;
   assign bus.ack = ack_ff;
   assign bus.rdata = rdata_ff;

endmodule : dfpr_regs

`default_nettype wire

// *** dfpr_pkg.sv ***
// Shared constants of the frequency offset register bank: register map,
// field layout, reset values, pull-range spans and update pacing.
// Assumes a single 50 MHz clock shared by both ends of the register port.
`default_nettype none

package dfpr_pkg;

   // Register addresses
   localparam logic [7:0] DFPR_ADDR_LOW = 8'h00;   // Low offset word
   localparam logic [7:0] DFPR_ADDR_HIGH = 8'h01;  // High offset word and drive enable
   localparam logic [7:0] DFPR_ADDR_RANGE = 8'h02; // Pull-range select

   // Field layout
   localparam int DFPR_OFFSET_W = 26;  // Whole signed offset
   localparam int DFPR_LOW_W = 16;     // Bits held in the low word
   localparam int DFPR_HIGH_W = 10;    // Bits held in the high word
   localparam int DFPR_DRIVE_BIT = 10; // Drive enable position in the high register
   localparam int DFPR_RANGE_W = 4;    // Pull-range select width
   localparam int DFPR_SPAN_W = 19;    // Span in hundredths of a ppm
   localparam int DFPR_SHIFT_W = 20;   // Signed applied shift in hundredths of a ppm
   localparam int DFPR_FS_SHIFT = 25;  // Full-scale word is 2^25-1

   // Reset values
   localparam logic [15:0] DFPR_LOW_RST = 16'h0000;
   localparam logic [9:0] DFPR_HIGH_RST = 10'h000;
   localparam logic DFPR_DRIVE_RST = 1'b0;
   localparam logic [25:0] DFPR_OFFSET_RST = 26'h0000000;

   // Largest and smallest offsets that stay inside the selected range
   localparam logic signed [25:0] DFPR_POS_FULL = 26'sh1ffffff; // 33,554,431
   localparam logic signed [25:0] DFPR_NEG_FULL = -26'sh1ffffff;

   // Update pacing: least time between two applied offsets
   localparam int DFPR_CLK_HZ = 50_000_000;
   localparam int DFPR_UPDATE_HZ = 38_000;
   localparam int DFPR_GAP_CYC = (DFPR_CLK_HZ + DFPR_UPDATE_HZ - 1) / DFPR_UPDATE_HZ;
   localparam int DFPR_GAP_W = 11;

   // Half-span of each pull-range code, hundredths of a ppm
   function automatic logic [18:0] dfpr_span(input logic [3:0] code);
      logic [18:0] s;
      case (code)
         4'h0: s = 19'd625;
         4'h1: s = 19'd1000;
         4'h2: s = 19'd1250;
         4'h3: s = 19'd2500;
         4'h4: s = 19'd5000;
         4'h5: s = 19'd8000;
         4'h6: s = 19'd10000;
         4'h7: s = 19'd12500;
         4'h8: s = 19'd15000;
         4'h9: s = 19'd20000;
         4'ha: s = 19'd40000;
         4'hb: s = 19'd60000;
         4'hc: s = 19'd80000;
         4'hd: s = 19'd120000;
         4'he: s = 19'd160000;
         default: s = 19'd320000;
      endcase
      return s;
   endfunction : dfpr_span

endpackage : dfpr_pkg

`default_nettype wire

// *** dfpr_if.sv ***
// Register port between the host controller and the frequency register bank.
// Assumes both ends run on the same clock; the serial protocol engine is outside.
`default_nettype none

interface dfpr_if (
   input wire logic clk,
   input wire logic resetn
);
   logic req;          // Host holds a request until ack
   logic we;           // Write when high, read when low
   logic [7:0] addr;   // Register address
   logic [15:0] wdata; // Write data
   logic ack;          // One-cycle answer from the bank
   logic [15:0] rdata; // Read data, valid with ack

   modport dev (input clk, input resetn, input req, input we, input addr, input wdata,
                output ack, output rdata);
   modport host (input clk, input resetn, output req, output we, output addr,
                 output wdata, input ack, input rdata);
endinterface : dfpr_if

`default_nettype wire

// *** dfpr_host.sv ***
// Host controller that programs the frequency register bank.
// Assumes dfpr_if on the bank side and a user that waits for cmd_ready.
`default_nettype none

module dfpr_host import dfpr_pkg::*; (
   dfpr_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [25:0] cmd_offset,
   input wire logic cmd_drive,
   input wire logic [3:0] cmd_range,
   input wire logic [7:0] cmd_addr,
   output logic rd_valid,
   output logic [15:0] rd_data
);

   // Command kinds
   localparam logic [1:0] KIND_OFFSET = 2'd0;
   localparam logic [1:0] KIND_RANGE = 2'd1;
   localparam logic [1:0] KIND_READ = 2'd2;

   typedef enum {DFPR_IDLE, DFPR_WR_LOW, DFPR_WR_HIGH, DFPR_WR_RANGE, DFPR_RD} dfpr_state_t;

   dfpr_state_t state_ff, nxt_state;
   logic [25:0] word_ff, nxt_word;    // Offset being sent
   logic drive_ff, nxt_drive;         // Drive bit sent with the high word
   logic [3:0] range_ff, nxt_range;   // Range being sent
   logic [7:0] raddr_ff, nxt_raddr;   // Read address
   logic [10:0] gap_ff, nxt_gap;      // Pacing between offset updates
   logic rdv_ff, nxt_rdv;
   logic [15:0] rdd_ff, nxt_rdd;

   // Offset commands wait out the pacing gap; others need only an idle host
   assign cmd_ready = (state_ff == DFPR_IDLE) &&
                      (cmd_kind != KIND_OFFSET || gap_ff == 11'd0); // RULE11

   // Command sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_word = word_ff;
      nxt_drive = drive_ff;
      nxt_range = range_ff;
      nxt_raddr = raddr_ff;
      nxt_gap = (gap_ff != 11'd0) ? gap_ff - 11'd1 : gap_ff;
      nxt_rdv = 1'b0;
      nxt_rdd = rdd_ff;
      case (state_ff)
         DFPR_IDLE: begin
            if (cmd_valid && cmd_ready) begin
               case (cmd_kind)
                  KIND_OFFSET: begin
                     nxt_word = cmd_offset;
                     nxt_drive = cmd_drive;
                     nxt_state = DFPR_WR_LOW; // RULE4
                  end
                  KIND_RANGE: begin
                     nxt_range = cmd_range;
                     nxt_state = DFPR_WR_RANGE;
                  end
                  KIND_READ: begin
                     nxt_raddr = cmd_addr;
                     nxt_state = DFPR_RD;
                  end
                  default: begin
                     nxt_state = DFPR_IDLE;
                  end
               endcase
            end
         end
         DFPR_WR_LOW: begin
            if (bus.ack) nxt_state = DFPR_WR_HIGH; // RULE4
         end
         DFPR_WR_HIGH: begin
            if (bus.ack) begin
               nxt_state = DFPR_IDLE;
               nxt_gap = 11'(DFPR_GAP_CYC - 1); // RULE11
            end
         end
         DFPR_WR_RANGE: begin
            if (bus.ack) nxt_state = DFPR_IDLE;
         end
         DFPR_RD: begin
            if (bus.ack) begin
               nxt_state = DFPR_IDLE;
               nxt_rdv = 1'b1;
               nxt_rdd = bus.rdata;
            end
         end
         default: begin
            nxt_state = DFPR_IDLE;
         end
      endcase
   end

   always_ff @(posedge bus.clk or negedge bus.resetn) begin
      if (!bus.resetn) begin
         state_ff <= DFPR_IDLE;
         word_ff <= DFPR_OFFSET_RST;
         drive_ff <= DFPR_DRIVE_RST;
         range_ff <= 4'h0;
         raddr_ff <= 8'h00;
         gap_ff <= 11'd0;
         rdv_ff <= 1'b0;
         rdd_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         word_ff <= nxt_word;
         drive_ff <= nxt_drive;
         range_ff <= nxt_range;
         raddr_ff <= nxt_raddr;
         gap_ff <= nxt_gap;
         rdv_ff <= nxt_rdv;
         rdd_ff <= nxt_rdd;
      end
   end

   // Bus drive, held steady while a request is outstanding
   always_comb begin
      bus.req = (state_ff != DFPR_IDLE);
      bus.we = (state_ff != DFPR_RD);
      bus.addr = DFPR_ADDR_LOW;
      bus.wdata = word_ff[15:0];
      case (state_ff)
         DFPR_WR_HIGH: begin
            bus.addr = DFPR_ADDR_HIGH;
            bus.wdata = {5'h00, drive_ff, word_ff[25:16]}; // RULE12 RULE8
         end
         DFPR_WR_RANGE: begin
            bus.addr = DFPR_ADDR_RANGE;
            bus.wdata = {12'h000, range_ff};
         end
         DFPR_RD: begin
            bus.addr = raddr_ff;
            bus.wdata = 16'h0000;
         end
         default: begin
         end
      endcase
   end

   assign rd_valid = rdv_ff;
   assign rd_data = rdd_ff;

endmodule : dfpr_host

`default_nettype wire

// *** dfpr_bus_sva.sv ***
// Protocol checker for the register port between host and bank.
// Assumes one clock; the bench instantiates it beside the interface.
`default_nettype none
module dfpr_bus_sva import dfpr_pkg::*; (
   input wire logic clk,
   input wire logic resetn,
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic ack,
   input wire logic [15:0] rdata
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   logic [10:0] gap_ff; // Cycles left before another high write may start
   logic [10:0] nxt_gap;
   // Reload at each high-word ack, so pacing is judged from the wire alone
   always_comb begin
      nxt_gap = gap_ff;
      if (ack && we && addr == DFPR_ADDR_HIGH) begin
         nxt_gap = 11'(DFPR_GAP_CYC - 1);
      end else if (gap_ff != 11'h000) begin
         nxt_gap = gap_ff - 11'h001;
      end
   end
   // Counter register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gap_ff <= 11'h000;
      end else begin
         gap_ff <= nxt_gap;
      end
   end
   sequence taken_s;
      req && !ack;
   endsequence
   sequence low_ack_s;
      ack && we && addr == DFPR_ADDR_LOW;
   endsequence
   sequence high_req_s;
      req && we && addr == DFPR_ADDR_HIGH;
   endsequence
   ack_answer_a: assert property (taken_s |=> ack)
      else $error("ack missing after request");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(ack) |-> $past(req))
      else $error("ack without request");
   req_hold_a: assert property (taken_s |=> req && $stable(addr) && $stable(wdata))
      else $error("request changed before ack");
   low_high_a: assert property (low_ack_s |-> ##[1:2] high_req_s)
      else $error("low word not followed by high word");
   high_pace_a: assert property (high_req_s |-> gap_ff == 11'h000)
      else $error("high word written too soon");
   high_rsvd_a: assert property (high_req_s |-> wdata[15:11] == 5'h00)
      else $error("unused high bits written");
   high_read_a: assert property (ack && !we && addr == DFPR_ADDR_HIGH
      |-> rdata[15:11] == 5'h00)
      else $error("unused high bits read nonzero");
   range_read_a: assert property (ack && !we && addr == DFPR_ADDR_RANGE
      |-> rdata[15:4] == 12'h000)
      else $error("unused range bits read nonzero");
   unmapped_zero_a: assert property (ack && !we && addr > DFPR_ADDR_RANGE
      |-> rdata == 16'h0000)
      else $error("unmapped read nonzero");
   wr_keep_a: assert property (ack && we |-> $stable(rdata))
      else $error("write disturbed read data");
endmodule : dfpr_bus_sva
`default_nettype wire

// *** dfpr_regs_test.sv ***
// Bench joining host controller and register bank over dfpr_if.
// Assumes package, interface and both design files compile first.
`default_nettype none
module dfpr_regs_test import dfpr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic sw_drive_mode = 1'b1; // Software drive control to begin with
   logic oe_pin = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_drive = 1'b0;
   logic [1:0] cmd_kind = 2'h0;
   logic [25:0] cmd_offset = 26'h0000000;
   logic [3:0] cmd_range = 4'h0;
   logic [7:0] cmd_addr = 8'h00;
   logic cmd_ready, drive_en, update_strobe, rd_valid;
   logic [25:0] applied_offset;
   logic [3:0] applied_range;
   logic signed [19:0] applied_shift;
   logic [15:0] rd_data;
   logic [25:0] cur_off = 26'h0000000; // Offset the bank should be using
   logic [3:0] cur_rng = 4'h9;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int last_upd = -10000; // Cycle of the previous applied offset
   // Half-spans per range code, hundredths of a ppm
   int spans [16] = '{625, 1000, 1250, 2500, 5000, 8000, 10000, 12500, 15000,
                      20000, 40000, 60000, 80000, 120000, 160000, 320000};
   dfpr_if bus_if (.clk(clk), .resetn(resetn));
   dfpr_regs u_dfpr_regs (.bus(bus_if), .sw_drive_mode(sw_drive_mode), .oe_pin(oe_pin),
      .drive_en(drive_en), .applied_offset(applied_offset), .applied_range(applied_range),
      .applied_shift(applied_shift), .update_strobe(update_strobe));
   dfpr_host u_dfpr_host (.bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_kind(cmd_kind), .cmd_offset(cmd_offset), .cmd_drive(cmd_drive),
      .cmd_range(cmd_range), .cmd_addr(cmd_addr), .rd_valid(rd_valid), .rd_data(rd_data));
   dfpr_bus_sva u_dfpr_bus_sva (.clk(clk), .resetn(resetn), .req(bus_if.req),
      .we(bus_if.we), .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack),
      .rdata(bus_if.rdata));
   always #10 clk = ~clk;
   // Verdict and end of run
   task automatic test_done();
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   // Hang guard: all tests need about 5.4k cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         test_done();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Floor of clamped offset times span over 2^25
   function automatic logic signed [19:0] exp_shift(input logic [25:0] o, input logic [3:0] r);
      longint v;
      v = longint'(signed'(o));
      if (v < -33554431) begin
         v = -33554431;
      end
      v = (v * spans[r]) >>> 25;
      return v[19:0];
   endfunction : exp_shift
   // One user command; entered and left at a falling edge
   task automatic cmd(input logic [1:0] k, input logic [25:0] o, input logic d,
                      input logic [3:0] r, input logic [7:0] a);
      int n;
      n = 0;
      cmd_kind = k;
      cmd_offset = o;
      cmd_drive = d;
      cmd_range = r;
      cmd_addr = a;
      // cmd_ready depends on the kind, so let it settle before trusting it
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask : cmd
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      int n;
      n = 0;
      cmd(2'h2, 26'h0000000, 1'b0, 4'h0, a);
      while (rd_valid !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(rd_data, e);
   endtask : rd
   // Offset write; the old offset must survive the low-word write
   task automatic set_off(input logic [25:0] o, input logic d);
      int n;
      n = 0;
      cmd(2'h0, o, d, 4'h0, 8'h00);
      while (update_strobe !== 1'b1 && n < 3000) begin
         if (bus_if.ack === 1'b1 && bus_if.addr === DFPR_ADDR_LOW) begin
            chk(applied_offset, cur_off);
         end
         @(negedge clk);
         n++;
      end
      cur_off = o;
      chk((cyc - last_upd) >= DFPR_GAP_CYC, 1'b1);
      last_upd = cyc;
      @(negedge clk);
      chk(applied_offset, o);
      chk(applied_shift, exp_shift(o, cur_rng));
   endtask : set_off
   // Range write applies at once; shift follows a cycle later
   task automatic set_rng(input logic [3:0] r);
      cmd(2'h1, 26'h0000000, 1'b0, r, 8'h00);
      repeat (3) @(negedge clk);
      cur_rng = r;
      chk(applied_range, r);
      chk(applied_shift, exp_shift(cur_off, r));
   endtask : set_rng
   initial begin
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      chk(applied_offset, 26'h0000000);
      chk(applied_shift, 20'h00000);
      chk(applied_range, 4'h9);
      chk(drive_en, 1'b0);
      rd(DFPR_ADDR_LOW, 16'h0000);
      rd(DFPR_ADDR_HIGH, 16'h0000);
      rd(DFPR_ADDR_RANGE, 16'h0009);
      set_off(26'h0e66666, 1'b1);
      chk(drive_en, 1'b1);
      rd(DFPR_ADDR_LOW, 16'h6666);
      rd(DFPR_ADDR_HIGH, 16'h04e6);
      set_off(26'h3800000, 1'b1);
      // Every range code against a negative quarter-scale offset
      for (int i = 0; i < 16; i++) begin
         set_rng(4'(i));
      end
      rd(DFPR_ADDR_RANGE, 16'h000f);
      set_off(26'h2000000, 1'b1);
      set_off(26'h1ffffff, 1'b1);
      rd(8'h05, 16'h0000);
      // Pin control: drive bit writes must be ignored
      sw_drive_mode = 1'b0;
      oe_pin = 1'b1;
      set_off(26'h0000123, 1'b0);
      chk(drive_en, 1'b1);
      oe_pin = 1'b0;
      repeat (3) @(negedge clk);
      chk(drive_en, 1'b0);
      sw_drive_mode = 1'b1;
      @(negedge clk);
      chk(drive_en, 1'b1);
      rd(DFPR_ADDR_HIGH, 16'h0400);
      test_done();
   end
endmodule : dfpr_regs_test
`default_nettype wire
